// >>> verilog/fvros_pkg.sv
/*
 Constants shared by the flash verify and read-once sequencer and its array memory.
 Assumes a single 50 MHz clock domain and a 16-bit parameter word.
*/
package fvros_pkg;
  localparam int unsigned CLK_HZ = 50000000;
  localparam logic [7:0] CMD_VERIFY_ALL = 8'h01;
  localparam logic [7:0] CMD_VERIFY_BLOCK = 8'h02;
  localparam logic [7:0] CMD_VERIFY_SECTION = 8'h03;
  localparam logic [7:0] CMD_READ_ONCE = 8'h04;
  localparam logic [2:0] IDX_CMD = 3'h0;
  localparam logic [2:0] IDX_ADDR_LO = 3'h1;
  localparam logic [2:0] IDX_COUNT = 3'h2;
  localparam logic [2:0] IDX_WORD3 = 3'h5;
  localparam logic [1:0] SEL_DATA_FLASH = 2'h0;
  localparam logic [1:0] SEL_PROG_FLASH = 2'h3;
  localparam logic [15:0] ONCE_INDEX_MAX = 16'h0007;
  localparam logic [2:0] PHRASE_ALIGN_MASK = 3'h7;
  localparam logic [2:0] PHRASE_BYTES = 3'h0;
  localparam int unsigned ONCE_PHRASES = 8;
  localparam int unsigned WORDS_PER_PHRASE = 4;
  localparam logic [17:0] PFLASH_BASE = 18'h00000;
  localparam logic [17:0] PFLASH_END = 18'h3ffff;
  localparam logic [17:0] DFLASH_SIZE = 18'h00100;
  localparam logic [17:0] PFLASH_SIZE = 18'h00100;
  typedef enum logic [2:0] {
    FVROS_IDLE,
    FVROS_VERIFY,
    FVROS_ONCE_READ,
    FVROS_ONCE_STORE,
    FVROS_DONE
  } fvros_state_t;
endpackage

// >>> verilog/fvros_once_mem.sv
/*
 Reserved one-time field: 8 phrases of four 16-bit words, registered read port.
 Contents are loaded through the write port by the surrounding program-once logic.
*/
`timescale 1ns/1ps
module fvros_once_mem #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned WIDTH = 16
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data_ff
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem[rd_addr];
    end
  end
endmodule

// >>> verilog/fvros_sequencer.sv
/*
 Command sequencer for erase-verify (all, block, section) and read-once.
 Assumes software loads the parameter array through the write port, then pulses launch
 while command_complete_flag is high; the array cell checker answers through the
 blank and error inputs while a verify runs.
*/
`timescale 1ns/1ps
module fvros_sequencer #(
  parameter int unsigned VERIFY_CYCLES = 256
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic param_wr,
  input wire logic [2:0] param_wr_index,
  input wire logic [15:0] param_wr_data,
  input wire logic [2:0] parameter_index,
  input wire logic [2:0] param_rd_index,
  input wire logic launch,
  input wire logic clock_divider_set,
  input wire logic special_mode,
  input wire logic clear_access_error,
  input wire logic clear_fault_flags,
  input wire logic flash_read,
  input wire logic flash_read_pflash,
  input wire logic cell_not_blank,
  input wire logic cell_read_error,
  input wire logic cell_uncorrectable,
  input wire logic once_wr_en,
  input wire logic [4:0] once_wr_addr,
  input wire logic [15:0] once_wr_data,
  output logic [15:0] param_rd_data_ff,
  output logic command_complete_flag_ff,
  output logic access_error_flag_ff,
  output logic verify_status_upper_ff,
  output logic verify_status_lower_ff,
  output logic single_fault_detect_flag_ff,
  output logic double_fault_detect_flag_ff,
  output logic read_invalid_ff,
  output logic pflash_busy_ff,
  output logic dflash_busy_ff
);
  fvros_pkg::fvros_state_t state_ff;
  logic [15:0] param_ff [6];
  logic [17:0] cnt_ff;
  logic [2:0] wcnt_ff;
  logic [15:0] once_rd_data;
  logic [4:0] once_rd_addr;
  logic cmd_ok;
  logic [7:0] cmd_code;
  logic [17:0] sec_addr;
  logic [17:0] sec_end;
  logic [1:0] blk_sel;
  logic once_running;

  function automatic logic [17:0] to18(input logic [15:0] v);
    to18 = {2'h0, v};
  endfunction

  // Block select decode is shared by the launch check and the busy tracking.
  function automatic logic sel_is_pflash(input logic [1:0] code);
    sel_is_pflash = (code == fvros_pkg::SEL_PROG_FLASH);
  endfunction

  function automatic logic sel_is_dflash(input logic [1:0] code);
    sel_is_dflash = (code == fvros_pkg::SEL_DATA_FLASH);
  endfunction

  assign cmd_code = param_ff[fvros_pkg::IDX_CMD][15:8];
  assign sec_addr = {param_ff[fvros_pkg::IDX_CMD][1:0], param_ff[fvros_pkg::IDX_ADDR_LO]};
  // A sum that wraps past 18 bits means the section runs off the top of program flash.
  assign sec_end = sec_addr + {param_ff[fvros_pkg::IDX_COUNT][14:0], 3'h0};
  assign blk_sel = param_ff[fvros_pkg::IDX_CMD][1:0];
  assign once_running = (state_ff == fvros_pkg::FVROS_ONCE_READ) || (state_ff == fvros_pkg::FVROS_ONCE_STORE);

  always_comb begin
    cmd_ok = 1'b0;
    if (clock_divider_set) begin
      case (cmd_code)
        fvros_pkg::CMD_VERIFY_ALL: begin
          cmd_ok = (parameter_index == fvros_pkg::IDX_CMD);
        end
        fvros_pkg::CMD_VERIFY_BLOCK: begin
          cmd_ok = (parameter_index == fvros_pkg::IDX_CMD) &&
                   (sel_is_dflash(blk_sel) || sel_is_pflash(blk_sel));
        end
        fvros_pkg::CMD_VERIFY_SECTION: begin
          cmd_ok = (parameter_index == fvros_pkg::IDX_COUNT) && special_mode &&
                   ((sec_addr[2:0] & fvros_pkg::PHRASE_ALIGN_MASK) == fvros_pkg::PHRASE_BYTES) &&
                   (sec_addr <= fvros_pkg::PFLASH_END) &&
                   (sec_end >= sec_addr) && (sec_end <= fvros_pkg::PFLASH_END);
        end
        fvros_pkg::CMD_READ_ONCE: begin
          cmd_ok = (parameter_index == fvros_pkg::IDX_ADDR_LO) && special_mode &&
                   (param_ff[fvros_pkg::IDX_ADDR_LO] <= fvros_pkg::ONCE_INDEX_MAX);
        end
        default: begin
          cmd_ok = 1'b0;
        end
      endcase
    end
  end

  // The read port runs one word ahead of the store, so the last word is taken as the counter wraps.
  assign once_rd_addr = {param_ff[fvros_pkg::IDX_ADDR_LO][2:0], wcnt_ff[1:0]};

  fvros_once_mem #(
    .DEPTH(fvros_pkg::ONCE_PHRASES * fvros_pkg::WORDS_PER_PHRASE),
    .WIDTH(16)
  ) u_once_mem (
    .clock(clock),
    .nrst(nrst),
    .wr_en(once_wr_en),
    .wr_addr(once_wr_addr),
    .wr_data(once_wr_data),
    .rd_addr(once_rd_addr),
    .rd_data_ff(once_rd_data)
  );

  // A launch is taken only when idle with no error pending; any other launch is ignored.
  logic launch_go;
  assign launch_go = launch && command_complete_flag_ff && !access_error_flag_ff;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= fvros_pkg::FVROS_IDLE;
      cnt_ff <= '0;
      wcnt_ff <= '0;
    end else begin
      case (state_ff)
        fvros_pkg::FVROS_IDLE: begin
          wcnt_ff <= '0;
          if (launch_go && cmd_ok) begin
            if (cmd_code == fvros_pkg::CMD_READ_ONCE) begin
              state_ff <= fvros_pkg::FVROS_ONCE_READ;
            end else begin
              state_ff <= fvros_pkg::FVROS_VERIFY;
              // A section count of zero still scans one phrase, since the counter exits at one.
              if (cmd_code == fvros_pkg::CMD_VERIFY_SECTION) begin
                cnt_ff <= to18(param_ff[fvros_pkg::IDX_COUNT]);
              end else begin
                // Whole-block verifies use a fixed scan length set by the parameter.
                cnt_ff <= 18'(VERIFY_CYCLES);
              end
            end
          end
        end
        fvros_pkg::FVROS_VERIFY: begin
          if (cnt_ff <= 18'h00001) begin
            state_ff <= fvros_pkg::FVROS_DONE;
          end else begin
            cnt_ff <= cnt_ff - 18'h00001;
          end
        end
        fvros_pkg::FVROS_ONCE_READ: begin
          state_ff <= fvros_pkg::FVROS_ONCE_STORE;
          wcnt_ff <= wcnt_ff + 3'h1;
        end
        fvros_pkg::FVROS_ONCE_STORE: begin
          wcnt_ff <= wcnt_ff + 3'h1;
          if (wcnt_ff == 3'(fvros_pkg::WORDS_PER_PHRASE)) begin
            state_ff <= fvros_pkg::FVROS_DONE;
          end
        end
        fvros_pkg::FVROS_DONE: begin
          state_ff <= fvros_pkg::FVROS_IDLE;
        end
        default: begin
          state_ff <= fvros_pkg::FVROS_IDLE;
        end
      endcase
    end
  end

  // Writes from software are ignored while busy so a running read-once cannot be corrupted.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 6; i++) begin
        param_ff[i] <= '0;
      end
    end else if (state_ff == fvros_pkg::FVROS_ONCE_STORE) begin
      // Read-once words land in slots two to five, one per cycle.
      param_ff[3'(32'(fvros_pkg::IDX_COUNT) + 32'(wcnt_ff) - 1)] <= once_rd_data;
    end else if (param_wr && command_complete_flag_ff && param_wr_index <= fvros_pkg::IDX_WORD3) begin
      param_ff[param_wr_index] <= param_wr_data;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      param_rd_data_ff <= '0;
    end else if (param_rd_index <= fvros_pkg::IDX_WORD3) begin
      param_rd_data_ff <= param_ff[param_rd_index];
    end else begin
      param_rd_data_ff <= '0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      command_complete_flag_ff <= 1'b1;
    end else if (state_ff == fvros_pkg::FVROS_DONE) begin
      command_complete_flag_ff <= 1'b1;
    end else if (launch_go && cmd_ok) begin
      command_complete_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      access_error_flag_ff <= 1'b0;
    end else if (launch && command_complete_flag_ff && !access_error_flag_ff && !cmd_ok) begin
      // A refused launch leaves the complete flag high, so software sees the error at once.
      access_error_flag_ff <= 1'b1;
    end else if (clear_access_error) begin
      access_error_flag_ff <= 1'b0;
    end
  end

  // Both bits clear at launch and only accumulate while a verify runs; a read-once leaves them clear.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      verify_status_upper_ff <= 1'b0;
      verify_status_lower_ff <= 1'b0;
    end else if (launch_go && cmd_ok) begin
      verify_status_upper_ff <= 1'b0;
      verify_status_lower_ff <= 1'b0;
    end else if (state_ff == fvros_pkg::FVROS_VERIFY) begin
      if (cell_not_blank) begin
        verify_status_upper_ff <= 1'b1;
        verify_status_lower_ff <= 1'b1;
      end
      if (cell_read_error) begin
        verify_status_upper_ff <= 1'b1;
      end
      if (cell_uncorrectable) begin
        verify_status_lower_ff <= 1'b1;
      end
    end
  end

  logic same_block_read;
  assign same_block_read = flash_read && !command_complete_flag_ff &&
                           (flash_read_pflash ? pflash_busy_ff : dflash_busy_ff);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pflash_busy_ff <= 1'b0;
      dflash_busy_ff <= 1'b0;
    end else if (launch_go && cmd_ok) begin
      pflash_busy_ff <= (cmd_code != fvros_pkg::CMD_VERIFY_BLOCK) || sel_is_pflash(blk_sel);
      dflash_busy_ff <= (cmd_code == fvros_pkg::CMD_VERIFY_ALL) ||
                        ((cmd_code == fvros_pkg::CMD_VERIFY_BLOCK) && sel_is_dflash(blk_sel));
    end else if (state_ff == fvros_pkg::FVROS_DONE) begin
      pflash_busy_ff <= 1'b0;
      dflash_busy_ff <= 1'b0;
    end
  end

  // Set wins over a simultaneous clear.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      single_fault_detect_flag_ff <= 1'b0;
      double_fault_detect_flag_ff <= 1'b0;
    end else if (same_block_read) begin
      single_fault_detect_flag_ff <= 1'b1;
      double_fault_detect_flag_ff <= 1'b1;
    end else if (clear_fault_flags) begin
      single_fault_detect_flag_ff <= 1'b0;
      double_fault_detect_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      read_invalid_ff <= 1'b0;
    end else begin
      read_invalid_ff <= same_block_read ||
                         (flash_read && flash_read_pflash && once_running);
    end
  end
endmodule

// >>> bench/fvros_seq_checker.sv
/*
 Checker for the sequencer's launch, error, status and fault flags.
 Assumes it is bound to fvros_sequencer and sees only its ports.
*/
`timescale 1ns/1ps
module fvros_seq_checker (
  input wire logic clock,
  input wire logic nrst,
  input wire logic launch,
  input wire logic clock_divider_set,
  input wire logic clear_access_error,
  input wire logic clear_fault_flags,
  input wire logic flash_read,
  input wire logic flash_read_pflash,
  input wire logic command_complete_flag_ff,
  input wire logic access_error_flag_ff,
  input wire logic verify_status_upper_ff,
  input wire logic verify_status_lower_ff,
  input wire logic single_fault_detect_flag_ff,
  input wire logic double_fault_detect_flag_ff,
  input wire logic read_invalid_ff,
  input wire logic pflash_busy_ff,
  input wire logic dflash_busy_ff
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_try;
    launch && command_complete_flag_ff && !access_error_flag_ff;
  endsequence
  sequence s_ok;
    s_try ##1 !command_complete_flag_ff;
  endsequence
  chk_launch_outcome: assert property (s_try |=> command_complete_flag_ff == access_error_flag_ff)
    else $error("launch gave neither a start nor an error");
  chk_divider_gate: assert property ((s_try ##0 !clock_divider_set) |=> access_error_flag_ff)
    else $error("launch without divider was not refused");
  chk_refused_launch: assert property (launch && access_error_flag_ff && command_complete_flag_ff &&
    !clear_access_error |=> access_error_flag_ff && command_complete_flag_ff)
    else $error("launch ran while the error flag was set");
  chk_error_stands: assert property (access_error_flag_ff && !clear_access_error |=> access_error_flag_ff)
    else $error("access error dropped without a clear");
  chk_error_clear: assert property (clear_access_error && !launch |=> !access_error_flag_ff)
    else $error("access error did not clear");
  chk_fault_read: assert property (flash_read && !command_complete_flag_ff &&
    (flash_read_pflash ? pflash_busy_ff : dflash_busy_ff)
    |=> read_invalid_ff && single_fault_detect_flag_ff && double_fault_detect_flag_ff)
    else $error("busy block read not flagged");
  chk_status_cleared: assert property (s_ok |-> !verify_status_upper_ff && !verify_status_lower_ff)
    else $error("verify status not cleared at launch");
  chk_idle_not_busy: assert property (command_complete_flag_ff |-> !pflash_busy_ff && !dflash_busy_ff)
    else $error("block busy while complete");
  chk_fault_stands: assert property (single_fault_detect_flag_ff && !clear_fault_flags |=> single_fault_detect_flag_ff)
    else $error("fault flag dropped without a clear");
endmodule
bind fvros_sequencer fvros_seq_checker u_chk (.clock(clock), .nrst(nrst), .launch(launch),
  .clock_divider_set(clock_divider_set), .clear_access_error(clear_access_error),
  .clear_fault_flags(clear_fault_flags), .flash_read(flash_read), .flash_read_pflash(flash_read_pflash),
  .command_complete_flag_ff(command_complete_flag_ff), .access_error_flag_ff(access_error_flag_ff),
  .verify_status_upper_ff(verify_status_upper_ff), .verify_status_lower_ff(verify_status_lower_ff),
  .single_fault_detect_flag_ff(single_fault_detect_flag_ff),
  .double_fault_detect_flag_ff(double_fault_detect_flag_ff), .read_invalid_ff(read_invalid_ff),
  .pflash_busy_ff(pflash_busy_ff), .dflash_busy_ff(dflash_busy_ff));

// >>> bench/fvros_sequencer_bench.sv
/*
 Self-checking bench: command sequences through the parameter array with expected flags.
 Assumes VERIFY_CYCLES of 4 so that a verify takes five cycles.
*/
`timescale 1ns/1ps
module fvros_sequencer_bench;
  logic clock = 0, nrst = 0, param_wr = 0, launch = 0, cds = 0, sp = 1, clr_ae = 0, clr_ff = 0;
  logic rd = 0, rd_pf = 1, nb = 0, re = 0, un = 0, o_we = 0;
  logic [2:0] wi = 0, pi = 0, ri = 0;
  logic [4:0] o_wa = 0;
  logic [15:0] wd = 0, o_wd = 0, rdat;
  logic cc, ae, up, lo, sf, df, inv, pb, db;
  int bad_count = 0, samples_checked = 0, cycles = 0;
  logic [15:0] e0 [11] = '{16'h0100, 16'h0201, 16'h0202, 16'h0300, 16'h0300, 16'h0303, 16'h0300,
    16'h0400, 16'h0400, 16'h0400, 16'h0900};
  logic [15:0] e1 [11] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h0004, 16'hfff8, 16'h0, 16'h0, 16'h0008, 16'h0, 16'h0};
  logic [2:0] e2 [11] = '{3'h0, 3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0};
  logic [2:0] ep [11] = '{3'h1, 3'h0, 3'h0, 3'h0, 3'h2, 3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0};
  logic es [11] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  fvros_sequencer #(.VERIFY_CYCLES(4)) u_dut (.clock(clock), .nrst(nrst), .param_wr(param_wr),
    .param_wr_index(wi), .param_wr_data(wd), .parameter_index(pi), .param_rd_index(ri), .launch(launch),
    .clock_divider_set(cds), .special_mode(sp), .clear_access_error(clr_ae), .clear_fault_flags(clr_ff),
    .flash_read(rd), .flash_read_pflash(rd_pf), .cell_not_blank(nb), .cell_read_error(re),
    .cell_uncorrectable(un), .once_wr_en(o_we), .once_wr_addr(o_wa), .once_wr_data(o_wd),
    .param_rd_data_ff(rdat), .command_complete_flag_ff(cc), .access_error_flag_ff(ae),
    .verify_status_upper_ff(up), .verify_status_lower_ff(lo), .single_fault_detect_flag_ff(sf),
    .double_fault_detect_flag_ff(df), .read_invalid_ff(inv), .pflash_busy_ff(pb), .dflash_busy_ff(db));
  always #10 clock = ~clock;
  // The whole run needs well under 600 cycles, so this ceiling only trips on a hang.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    if (bad_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] i, input logic [15:0] d);
    @(negedge clock);
    param_wr = 1;
    wi = i;
    wd = d;
    @(negedge clock);
    param_wr = 0;
  endtask
  task automatic go(input logic [15:0] w0, input logic [15:0] w1, input logic [2:0] w2, input logic [2:0] p);
    wr(3'h0, w0);
    wr(3'h1, w1);
    wr(3'h2, {13'h0, w2});
    pi = p;
    launch = 1;
    @(negedge clock);
    launch = 0;
  endtask
  task automatic flags(input logic c, input logic a);
    @(negedge clock);
    cmp("complete", {15'h0, c}, {15'h0, cc});
    cmp("access_error", {15'h0, a}, {15'h0, ae});
  endtask
  task automatic clear;
    @(negedge clock);
    clr_ae = 1;
    @(negedge clock);
    clr_ae = 0;
  endtask
  task automatic run(input logic [15:0] w0, input logic [15:0] w1, input logic [2:0] w2, input logic [2:0] p,
    input logic [2:0] cells, input logic [1:0] st, input logic [1:0] bz, input int lim, input logic prd);
    int n;
    {nb, re, un} = cells;
    go(w0, w1, w2, p);
    cmp("complete", 16'h0, {15'h0, cc});
    cmp("busy", {14'h0, bz}, {14'h0, pb, db});
    if (prd) begin
      rd = 1;
      @(negedge clock);
      rd = 0;
      cmp("read_invalid", 16'h1, {15'h0, inv});
      cmp("fault_flags", 16'h3, {14'h0, sf, df});
      clr_ff = 1;
      @(negedge clock);
      clr_ff = 0;
      cmp("fault_flags", 16'h0, {14'h0, sf, df});
    end
    n = 0;
    while (cc !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
    cmp("complete", 16'h1, {15'h0, cc});
    cmp("verify_status", {14'h0, st}, {14'h0, up, lo});
    cmp("busy", 16'h0, {14'h0, pb, db});
    {nb, re, un} = 3'h0;
  endtask
  initial begin
    repeat (3) @(negedge clock);
    nrst = 1;
    cmp("complete", 16'h1, {15'h0, cc});
    for (int k = 0; k < 4; k++) begin
      @(negedge clock);
      o_we = 1;
      o_wa = {3'h7, 2'(k)};
      o_wd = 16'h5a50 + 16'(k);
    end
    @(negedge clock);
    o_we = 0;
    go(16'h0100, 16'h0, 3'h0, 3'h0);
    flags(1, 1);
    go(16'h0100, 16'h0, 3'h0, 3'h0);
    flags(1, 1);
    clear();
    flags(1, 0);
    cds = 1;
    for (int k = 0; k < 11; k++) begin
      sp = es[k];
      go(e0[k], e1[k], e2[k], ep[k]);
      flags(1, 1);
      clear();
    end
    sp = 1;
    run(16'h0100, 16'h0, 3'h0, 3'h0, 3'h0, 2'h0, 2'h3, 8, 0);
    run(16'h0203, 16'h0, 3'h0, 3'h0, 3'h4, 2'h3, 2'h2, 8, 1);
    rd_pf = 0;
    run(16'h0200, 16'h0, 3'h0, 3'h0, 3'h2, 2'h2, 2'h1, 8, 1);
    rd_pf = 1;
    run(16'h0100, 16'h0, 3'h0, 3'h0, 3'h3, 2'h3, 2'h3, 8, 0);
    run(16'h0300, 16'h0010, 3'h2, 3'h2, 3'h4, 2'h3, 2'h2, 6, 0);
    run(16'h0400, 16'h0007, 3'h0, 3'h1, 3'h0, 2'h0, 2'h2, 9, 1);
    for (int k = 2; k < 6; k++) begin
      ri = 3'(k);
      @(negedge clock);
      @(negedge clock);
      cmp("once_word", 16'h5a50 + 16'(k - 2), rdat);
    end
    give_verdict();
  end
endmodule
